// file: dbsc_dev.sv
// driver end: serial shift register, two config words, bridge timers
// assumes oscillator, chop and trip inputs are asynchronous pins
//
// Decided for this implementation: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module dbsc_dev (
   input  wire logic       SYS_CLK,
   input  wire logic       ARST_N,
   dbsc_if.dev             LINK,
   input  wire logic       OSC_IN,
   input  wire logic [1:0] CHOP_IN,
   input  wire logic [1:0] TRIP_IN,
   output logic      [1:0] DRV_ON,
   output logic      [1:0] DIR_FWD,
   output logic      [1:0] DECAY_FAST,
   output logic      [1:0] SENSE_BLANK,
   output logic      [1:0] REF_DIV5,
   output logic      [3:0] SR_MODE,
   output logic            IDLE,
   output logic            TEST_MODE
);
   // ********************************************************
   // state
   // ********************************************************
   typedef enum logic [1:0] {PH_EXT, PH_ON, PH_OFF} dbsc_ph_e;

   typedef struct packed {
      logic [7:0]            s1;      // first synchroniser stage
      logic [7:0]            s2;      // second synchroniser stage
      logic [7:0]            s3;      // previous value for edges
      logic [19:0]           sr;      // shift register
      logic [4:0]            nbits;   // bits shifted this frame
      logic [1:0][19:0]      cfg;     // held words per bridge
      dbsc_ph_e [1:0]        ph;      // bridge phase
      logic [1:0][8:0]       cnt;     // oscillator period count
      logic [1:0]            drv;
      logic [1:0]            fwd;
      logic [1:0]            fast;
      logic [1:0]            blank;
      logic [1:0]            div5;
      logic [1:0][1:0]       srm;
      logic                  idle;
      logic                  test;
   } dbsc_dev_s;

   dbsc_dev_s q;
   dbsc_dev_s d;

   // synchronised input positions
   localparam int I_SCLK = 0;
   localparam int I_SDAT = 1;
   localparam int I_LDN  = 2;
   localparam int I_OSC  = 3;
   localparam int I_CHOP = 4;
   localparam int I_TRIP = 6;

   localparam logic [4:0] NBITS_FULL = 5'(dbsc_pkg::WORD_W);
   localparam logic [4:0] NBITS_OVER = 5'(dbsc_pkg::WORD_W + 1);

   // ********************************************************
   // next state
   // ********************************************************
   // link decode, word load and per-bridge timers
   always_comb begin
      logic       sclk_rise;
      logic       ld_rise;
      logic       ld_fall;
      logic       tick;
      logic       on_req;
      logic       trip;
      logic [19:0] c;
      logic [8:0] blen;
      logic [8:0] toff;
      logic [8:0] tfd;
      sclk_rise = 1'b0;
      ld_rise   = 1'b0;
      ld_fall   = 1'b0;
      tick      = 1'b0;
      on_req    = 1'b0;
      trip      = 1'b0;
      c         = dbsc_pkg::CFG_RST;
      blen      = dbsc_pkg::BLANK_0;
      toff      = 9'h000;
      tfd       = 9'h000;
      d = q;

      // every pin passes two flops before use
      d.s1 = {TRIP_IN, CHOP_IN, OSC_IN, LINK.ld_n, LINK.sdata, LINK.sclk};
      d.s2 = q.s1;
      d.s3 = q.s2;
      sclk_rise = q.s2[I_SCLK] & ~q.s3[I_SCLK];
      ld_rise   = q.s2[I_LDN] & ~q.s3[I_LDN];
      ld_fall   = ~q.s2[I_LDN] & q.s3[I_LDN];
      tick      = q.s2[I_OSC] & ~q.s3[I_OSC];

      // shift in while the strobe is low, msb arrives first
      if (ld_fall) begin
         d.nbits = 5'h00;
      end else if (~q.s2[I_LDN] && sclk_rise) begin
         d.sr = {q.sr[18:0], q.s2[I_SDAT]};
         if (q.nbits != NBITS_OVER) begin
            d.nbits = q.nbits + 5'h01;
         end
      end

      // strobe rise commits only a word of exactly twenty bits
      if (ld_rise && q.nbits == NBITS_FULL) begin
         d.cfg[q.sr[dbsc_pkg::SEL_BIT]] = q.sr;
      end

      // idle when bridge two word holds a zero in its top bit
      d.idle = ~d.cfg[1][dbsc_pkg::TESTIDL_BIT];
      d.test = d.cfg[0][dbsc_pkg::TESTIDL_BIT];

      for (int b = 0; b < 2; b++) begin
         c      = q.cfg[b];
         on_req = q.s2[I_CHOP + b] ^ c[dbsc_pkg::POL_BIT];
         trip   = q.s2[I_TRIP + b];
         case (c[dbsc_pkg::BLANK_LSB +: 2])
            2'h0: blen = dbsc_pkg::BLANK_0;
            2'h1: blen = dbsc_pkg::BLANK_1;
            2'h2: blen = dbsc_pkg::BLANK_2;
            default: blen = dbsc_pkg::BLANK_3;
         endcase
         toff = {({1'b0, c[dbsc_pkg::OFF_LSB +: dbsc_pkg::OFF_W]} + 6'h01), 3'h0} - 9'h001;
         tfd  = {1'b0, {({1'b0, c[dbsc_pkg::FD_LSB +: dbsc_pkg::FD_W]} + 5'h01), 3'h0}
                 - 8'h01};

         // chopped or idle bridges leave the internal loop
         if (d.idle || !on_req) begin
            d.ph[b]  = PH_EXT;
            d.cnt[b] = 9'h000;
         end else begin
            case (q.ph[b])
               PH_EXT: begin
                  d.ph[b]  = PH_ON;
                  d.cnt[b] = 9'h000;
               end
               PH_ON: begin
                  if (q.cnt[b] < blen) begin
                     if (tick) begin
                        d.cnt[b] = q.cnt[b] + 9'h001;
                     end
                  end else if (trip) begin
                     d.ph[b]  = PH_OFF;
                     d.cnt[b] = 9'h000;
                  end
               end
               PH_OFF: begin
                  if (tick) begin
                     if (q.cnt[b] + 9'h001 >= toff) begin
                        d.ph[b]  = PH_ON;
                        d.cnt[b] = 9'h000;
                     end else begin
                        d.cnt[b] = q.cnt[b] + 9'h001;
                     end
                  end
               end
               default: begin
                  d.ph[b]  = PH_EXT;
                  d.cnt[b] = 9'h000;
               end
            endcase
         end

         // outputs follow the next phase so they leave straight from flops
         d.drv[b]   = !d.idle && d.ph[b] == PH_ON;
         d.blank[b] = d.ph[b] == PH_ON && d.cnt[b] < blen;
         if (d.idle) begin
            d.fast[b] = 1'b0;
         end else if (d.ph[b] == PH_EXT) begin
            d.fast[b] = ~c[dbsc_pkg::XDECAY_BIT];
         end else if (d.ph[b] == PH_OFF) begin
            d.fast[b] = ~c[dbsc_pkg::IDECAY_BIT] && d.cnt[b] < tfd;
         end else begin
            d.fast[b] = 1'b0;
         end
         d.fwd[b]  = c[dbsc_pkg::DIR_BIT];
         d.div5[b] = c[dbsc_pkg::REFDIV_BIT];
         d.srm[b]  = c[dbsc_pkg::SR_LSB +: 2];
      end
   end

   // ********************************************************
   // registers
   // ********************************************************
   // reset clears the held words, which also forces idle
   always_ff @(posedge SYS_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         q       <= '0;
         q.s1    <= 8'h04;
         q.s2    <= 8'h04;
         q.s3    <= 8'h04;
         q.idle  <= 1'b1;
      end else begin
         q <= d;
      end
   end

   // ********************************************************
   // outputs
   // ********************************************************
   // all outputs are register fields of the state
   assign DRV_ON      = q.drv;
   assign DIR_FWD     = q.fwd;
   assign DECAY_FAST  = q.fast;
   assign SENSE_BLANK = q.blank;
   assign REF_DIV5    = q.div5;
   assign SR_MODE     = {q.srm[1], q.srm[0]};
   assign IDLE        = q.idle;
   assign TEST_MODE   = q.test;
endmodule
`default_nettype wire

// file: dbsc_host.sv
// host end: AXI4-Lite register slave that shifts words onto the link
// assumes the bus master keeps valid and payload until its handshake
`timescale 1ns/1ps
`default_nettype none
module dbsc_host #(
   parameter int IDLE_SETTLE = dbsc_pkg::IDLE_SETTLE_CYC
) (
   input  wire logic        SYS_CLK,
   input  wire logic        ARST_N,
   input  wire logic [3:0]  S_AXI_AWADDR,
   input  wire logic        S_AXI_AWVALID,
   output logic             S_AXI_AWREADY,
   input  wire logic [31:0] S_AXI_WDATA,
   input  wire logic [3:0]  S_AXI_WSTRB,
   input  wire logic        S_AXI_WVALID,
   output logic             S_AXI_WREADY,
   output logic [1:0]       S_AXI_BRESP,
   output logic             S_AXI_BVALID,
   input  wire logic        S_AXI_BREADY,
   input  wire logic [3:0]  S_AXI_ARADDR,
   input  wire logic        S_AXI_ARVALID,
   output logic             S_AXI_ARREADY,
   output logic [31:0]      S_AXI_RDATA,
   output logic [1:0]       S_AXI_RRESP,
   output logic             S_AXI_RVALID,
   input  wire logic        S_AXI_RREADY,
   dbsc_if.host             LINK
);
   // ********************************************************
   // state
   // ********************************************************
   typedef enum logic [1:0] {SH_IDLE, SH_LOW, SH_HIGH, SH_DONE} dbsc_sh_e;

   typedef struct packed {
      logic        awready;
      logic        wready;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        arready;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
      dbsc_sh_e    st;
      logic [19:0] sh;
      logic [4:0]  bitn;
      logic [2:0]  div;
      logic        sclk;
      logic        sdata;
      logic        ld_n;
      logic [16:0] wait_cnt;  // time since idle bit went high
      logic        settled;
   } dbsc_host_s;

   dbsc_host_s q;
   dbsc_host_s d;

   localparam logic [16:0] SETTLE_M1 = 17'(IDLE_SETTLE - 1);
   localparam logic [4:0]  LAST_BIT  = 5'(dbsc_pkg::WORD_W - 1);

   // ********************************************************
   // next state
   // ********************************************************
   // bus slave, settle timer and serial shifter
   always_comb begin
      logic [19:0] w;
      w = S_AXI_WDATA[19:0];
      d = q;

      // settle timer runs once the idle bit has been sent high
      // evaluated first so that a restarting write below overrides it
      if (q.wait_cnt != 17'h00000 && !q.settled) begin
         if (q.wait_cnt == SETTLE_M1) begin
            d.settled  = 1'b1;
            d.wait_cnt = 17'h00000;
         end else begin
            d.wait_cnt = q.wait_cnt + 17'h00001;
         end
      end

      // write channel: ready for one cycle once both valids stand
      if (q.awready) begin
         d.awready = 1'b0;
         d.wready  = 1'b0;
         d.bvalid  = 1'b1;
         d.bresp   = dbsc_pkg::RESP_SLVERR;
         if (S_AXI_AWADDR == dbsc_pkg::REG_WORD && q.st == SH_IDLE
             && S_AXI_WSTRB[2:0] == 3'h7) begin
            d.bresp = dbsc_pkg::RESP_OKAY;
            if (!w[dbsc_pkg::SEL_BIT]) begin
               w[dbsc_pkg::TESTIDL_BIT] = 1'b0;
            end else if (!w[dbsc_pkg::TESTIDL_BIT]) begin
               d.settled  = 1'b0;
               d.wait_cnt = 17'h00000;
            end else if (!q.settled && q.wait_cnt == 17'h00000) begin
               d.wait_cnt = 17'h00001;
            end
            d.sh    = {w[18:0], 1'b0};
            d.sdata = w[19];
            d.sclk  = 1'b0;
            d.ld_n  = 1'b0;
            d.div   = 3'h0;
            d.bitn  = 5'h00;
            d.st    = SH_LOW;
         end
      end else if (S_AXI_AWVALID && S_AXI_WVALID && !q.bvalid) begin
         d.awready = 1'b1;
         d.wready  = 1'b1;
      end
      if (q.bvalid && S_AXI_BREADY) begin
         d.bvalid = 1'b0;
      end

      // read channel
      if (q.arready) begin
         d.arready = 1'b0;
         d.rvalid  = 1'b1;
         d.rdata   = 32'h00000000;
         d.rresp   = dbsc_pkg::RESP_OKAY;
         if (S_AXI_ARADDR == dbsc_pkg::REG_STAT) begin
            d.rdata[dbsc_pkg::STAT_BUSY]  = q.st != SH_IDLE;
            d.rdata[dbsc_pkg::STAT_SETTL] = q.settled;
         end else begin
            d.rresp = dbsc_pkg::RESP_SLVERR;
         end
      end else if (S_AXI_ARVALID && !q.rvalid) begin
         d.arready = 1'b1;
      end
      if (q.rvalid && S_AXI_RREADY) begin
         d.rvalid = 1'b0;
      end

      // shifter: data changes while the clock is low
      case (q.st)
         SH_LOW: begin
            d.div = q.div + 3'h1;
            if (q.div == dbsc_pkg::SCLK_HALF_M1) begin
               d.div  = 3'h0;
               d.sclk = 1'b1;
               d.st   = SH_HIGH;
            end
         end
         SH_HIGH: begin
            d.div = q.div + 3'h1;
            if (q.div == dbsc_pkg::SCLK_HALF_M1) begin
               d.div  = 3'h0;
               d.sclk = 1'b0;
               if (q.bitn == LAST_BIT) begin
                  d.st = SH_DONE;
               end else begin
                  d.bitn  = q.bitn + 5'h01;
                  d.sdata = q.sh[19];
                  d.sh    = {q.sh[18:0], 1'b0};
                  d.st    = SH_LOW;
               end
            end
         end
         SH_DONE: begin
            d.div = q.div + 3'h1;
            if (q.div == dbsc_pkg::SCLK_HALF_M1) begin
               d.div  = 3'h0;
               d.ld_n = 1'b1;
               d.st   = SH_IDLE;
            end
         end
         default: begin
            // idle: leave alone a shift that a write has just started
         end
      endcase
   end

   // ********************************************************
   // registers
   // ********************************************************
   // strobe idles high, everything else low
   always_ff @(posedge SYS_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         q      <= '0;
         q.ld_n <= 1'b1;
      end else begin
         q <= d;
      end
   end

   // ********************************************************
   // outputs
   // ********************************************************
   assign S_AXI_AWREADY = q.awready;
   assign S_AXI_WREADY  = q.wready;
   assign S_AXI_BVALID  = q.bvalid;
   assign S_AXI_BRESP   = q.bresp;
   assign S_AXI_ARREADY = q.arready;
   assign S_AXI_RVALID  = q.rvalid;
   assign S_AXI_RDATA   = q.rdata;
   assign S_AXI_RRESP   = q.rresp;
   assign LINK.sclk     = q.sclk;
   assign LINK.sdata    = q.sdata;
   assign LINK.ld_n     = q.ld_n;
endmodule
`default_nettype wire

// file: dbsc_if.sv
// three-wire serial configuration link between host and driver
// assumes both ends run from their own system clock
`timescale 1ns/1ps
`default_nettype none
interface dbsc_if;
   logic sclk;    // shift clock
   logic sdata;   // serial data, msb first
   logic ld_n;    // load strobe, idles high
   modport dev  (input sclk, input sdata, input ld_n);
   modport host (output sclk, output sdata, output ld_n);
endinterface
`default_nettype wire

// file: dbsc_pkg.sv
// shared constants for the dual bridge serial configuration port
// assumes a 100 MHz system clock on both ends of the three-wire link
// Functional notes
// - configuration only over clock, data, strobe wires
// - each transfer is 20 bits: select plus 19
// - words shift most significant bit first
// - select bit routes word to bridge one/two
// - blank sense 4/6/12/24 oscillator periods after turn-on
// - off time is 8*(1+N)-1 oscillator periods
// - fast decay part 8*(1+N)-1, mixed only
// - fast longer than off means all fast
// - two bits pick synchronous rectifier mode
// - external chop decay: 0 fast, 1 slow
// - on when enable pin and polarity differ
// - direction bit: 1 forward, 0 reverse
// - reference divider bit: 0 by ten, 1 five
// - internal off decay: 0 mixed, 1 slow
// - host writes test bit zero in word one
// - idle bit zero disables outputs, stops pump; here only DRV_ON, DECAY_FAST, SENSE_BLANK go low
// - host holds idle bit high 1 ms first; dbsc_host only times this and reports it in the STAT_SETTL bit
// - data sampled on shift clock rise, strobe low
// - reset clears all configuration bits to zero
// - current trip ends on time, starts off time
package dbsc_pkg;
   // ********************************************************
   // word layout
   // ********************************************************
   localparam int WORD_W      = 20;
   localparam int BLANK_LSB   = 0;
   localparam int OFF_LSB     = 2;
   localparam int OFF_W       = 5;
   localparam int FD_LSB      = 7;
   localparam int FD_W        = 4;
   localparam int SR_LSB      = 11;
   localparam int XDECAY_BIT  = 13;
   localparam int POL_BIT     = 14;
   localparam int DIR_BIT     = 15;
   localparam int REFDIV_BIT  = 16;
   localparam int IDECAY_BIT  = 17;
   localparam int SEL_BIT     = 18;
   localparam int TESTIDL_BIT = 19;
   localparam logic [19:0] CFG_RST = 20'h00000;
   // blank lengths in oscillator periods per code
   localparam logic [8:0] BLANK_0 = 9'h004;
   localparam logic [8:0] BLANK_1 = 9'h006;
   localparam logic [8:0] BLANK_2 = 9'h00C;
   localparam logic [8:0] BLANK_3 = 9'h018;
   // ********************************************************
   // timing
   // ********************************************************
   localparam int SYS_CLK_MHZ     = 100;
   localparam int SCLK_PERIOD_NS  = 80;
   localparam logic [2:0] SCLK_HALF_M1 = 3'(SCLK_PERIOD_NS * SYS_CLK_MHZ / 2000 - 1);
   localparam int IDLE_SETTLE_US  = 1000;
   localparam int IDLE_SETTLE_CYC = IDLE_SETTLE_US * SYS_CLK_MHZ;
   // ********************************************************
   // host register map (AXI4-Lite, byte addresses)
   // ********************************************************
   localparam logic [3:0] REG_WORD   = 4'h0;
   localparam logic [3:0] REG_STAT   = 4'h4;
   localparam int         STAT_BUSY  = 0;
   localparam int         STAT_SETTL = 1;
   localparam logic [1:0] RESP_OKAY  = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// file: dbsc_sva.sv
// link checker: framing, phase lengths and bit count on the three wires
// assumes the signals of the interface joining host end and driver end
`timescale 1ns/1ps
`default_nettype none
module dbsc_sva (
   input wire logic SYS_CLK,
   input wire logic ARST_N,
   input wire logic sclk,
   input wire logic sdata,
   input wire logic ld_n
);
   // ********************************************************
   // helper: shift clock rises seen inside the current frame
   // ********************************************************
   logic [4:0] rise_q;

   // count rises while the strobe is low, clear between frames
   always_ff @(posedge SYS_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         rise_q <= 5'h00;
      end else if (ld_n) begin
         rise_q <= 5'h00;
      end else if ($rose(sclk)) begin
         rise_q <= rise_q + 5'h01;
      end
   end

   // ********************************************************
   // properties
   // ********************************************************
   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (!ARST_N);

   // one high phase of four cycles, then the fall
   sequence s_high;
      sclk [*4] ##1 !sclk;
   endsequence
   // one low phase of four cycles, then the rise
   sequence s_low;
      !sclk [*4] ##1 sclk;
   endsequence

   chk_clk_parked: assert property (ld_n |-> !sclk)
      else $error("shift clock moves outside a frame");
   chk_high_phase: assert property ($rose(sclk) |-> s_high)
      else $error("shift clock high phase wrong");
   chk_low_phase: assert property ($fell(sclk) && rise_q < 5'h14 |-> s_low)
      else $error("shift clock low phase wrong");
   chk_frame_open: assert property ($fell(ld_n) |-> s_low)
      else $error("frame start wrong");
   chk_data_held: assert property (sclk |-> $stable(sdata))
      else $error("data moves while shift clock high");
   chk_bit_total: assert property ($rose(ld_n) |-> rise_q == 5'h14)
      else $error("frame bit count not 20");
   chk_strobe_tail: assert property ($fell(sclk) && rise_q == 5'h14 |-> !ld_n [*4] ##1 ld_n)
      else $error("strobe release after last bit wrong");
   chk_frame_len: assert property ($fell(ld_n) |-> ##164 $rose(ld_n))
      else $error("frame length wrong");
endmodule
`default_nettype wire

// file: tb.sv
// testbench: host end and driver end joined over the link
// assumes dbsc_pkg, dbsc_if, dbsc_dev, dbsc_host and dbsc_sva compiled first
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin error_cnt++; \
   $display("[ERR] %0t got %h want %h", $time, (a), (b)); end end
module tb;
   // ********************************************************
   // signals and instances
   // ********************************************************
   typedef struct packed {logic [19:0] w; logic c; logic [5:0] e;} dbsc_row_s;
   logic        sys_clk, arst_n, osc_in, idle, test_mode;
   logic [1:0]  chop_in, trip_in, drv_on, dir_fwd, decay_fast, sense_blank, ref_div5;
   logic [3:0]  sr_mode, awaddr, wstrb, araddr;
   logic        awvalid, awready, wvalid, wready, bvalid, bready;
   logic        arvalid, arready, rvalid, rready;
   logic [31:0] wdata, rdata, d;
   logic [1:0]  bresp, rresp, r;
   logic [19:0] sh, last_w;
   int          nb, last_n, osc_cnt, osc_div, error_cnt, check_count, n0, n1, n2, b;
   // word, chop pin, expected {on, fast, div5, dir, sr}
   dbsc_row_s   rows [5] = '{'{20'hC8000, 1'b0, 6'h14}, '{20'h19800, 1'b1, 6'h2F},
      '{20'h07000, 1'b1, 6'h02}, '{20'hC4800, 1'b0, 6'h21}, '{20'h90000, 1'b0, 6'h18}};
   // mixed decay words: fast part shorter, then longer than the off time
   logic [19:0] mix_w [2] = '{20'h00004, 20'h00184};

   dbsc_if link ();
   dbsc_dev i_dbsc_dev (.SYS_CLK(sys_clk), .ARST_N(arst_n), .LINK(link), .OSC_IN(osc_in),
      .CHOP_IN(chop_in), .TRIP_IN(trip_in), .DRV_ON(drv_on), .DIR_FWD(dir_fwd),
      .DECAY_FAST(decay_fast), .SENSE_BLANK(sense_blank), .REF_DIV5(ref_div5),
      .SR_MODE(sr_mode), .IDLE(idle), .TEST_MODE(test_mode));
   dbsc_host #(.IDLE_SETTLE(20)) i_dbsc_host (.SYS_CLK(sys_clk), .ARST_N(arst_n),
      .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
      .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid),
      .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
      .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
      .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
      .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .LINK(link));
   dbsc_sva i_dbsc_sva (.SYS_CLK(sys_clk), .ARST_N(arst_n), .sclk(link.sclk),
      .sdata(link.sdata), .ld_n(link.ld_n));

   // 100 MHz system clock
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   // 5 MHz oscillator pin, rises counted for the timer checks
   always @(posedge sys_clk) begin
      if (osc_div == 9) begin
         osc_div <= 0;
         osc_in <= ~osc_in;
         if (!osc_in) osc_cnt <= osc_cnt + 1;
      end else osc_div <= osc_div + 1;
   end
   // wire watcher: bits as they cross, word and count at strobe release
   always @(posedge link.sclk) if (!link.ld_n) begin
      sh <= {sh[18:0], link.sdata};
      nb <= nb + 1;
   end
   always @(negedge link.ld_n) nb <= 0;
   always @(posedge link.ld_n) begin
      last_w <= sh;
      last_n <= nb;
   end

   // ********************************************************
   // tasks
   // ********************************************************
   function automatic logic pick(input int s);
      case (s)
         0: pick = link.ld_n;
         1: pick = drv_on[0];
         2: pick = sense_blank[0];
         default: pick = decay_fast[0];
      endcase
   endfunction
   task automatic complete_run;
      if (error_cnt == 0 && check_count > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic ran_out;
      error_cnt++;
      $display("[ERR] %0t wait ran out", $time);
      complete_run();
   endtask
   task automatic wait_for(input int s, input logic v);
      for (int i = 0; i < 5000; i++) begin
         @(posedge sys_clk);
         if (pick(s) === v) return;
      end
      ran_out();
   endtask
   task automatic axi_wr(input logic [3:0] a, input logic [31:0] v, output logic [1:0] rs);
      @(posedge sys_clk);
      awaddr <= a;
      wdata <= v;
      wstrb <= 4'hF;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (int i = 0; i < 100; i++) begin
         @(posedge sys_clk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid) begin
            rs = bresp;
            bready <= 1'b0;
            return;
         end
      end
      ran_out();
   endtask
   task automatic axi_rd(input logic [3:0] a, output logic [31:0] v, output logic [1:0] rs);
      @(posedge sys_clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (int i = 0; i < 100; i++) begin
         @(posedge sys_clk);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid) begin
            v = rdata;
            rs = rresp;
            rready <= 1'b0;
            return;
         end
      end
      ran_out();
   endtask
   // one word through the register bus, checked on the wire
   task automatic send(input logic [19:0] w);
      axi_wr(dbsc_pkg::REG_WORD, {12'h000, w}, r);
      `CHK(r, dbsc_pkg::RESP_OKAY)
      wait_for(0, 1'b1);
      repeat (8) @(posedge sys_clk);
      `CHK(last_w, {w[19] & w[18], w[18:0]})
      `CHK(last_n, 20)
   endtask

   // ********************************************************
   // main sequence
   // ********************************************************
   initial begin
      {arst_n, osc_in, osc_div, osc_cnt, chop_in, trip_in, nb, sh} = '0;
      {awaddr, wdata, wstrb, awvalid, wvalid, bready, araddr, arvalid, rready} = '0;
      error_cnt = 0;
      check_count = 0;
      repeat (6) @(posedge sys_clk);
      `CHK({idle, drv_on, sr_mode, test_mode, link.ld_n, link.sclk}, 10'h202)
      arst_n <= 1'b1;
      repeat (4) @(posedge sys_clk);
      // table of words and the outputs they should give
      foreach (rows[k]) begin
         b = int'(rows[k].w[18]);
         chop_in[b] <= rows[k].c;
         send(rows[k].w);
         `CHK({drv_on[b], ref_div5[b], dir_fwd[b], sr_mode[2*b+:2]}, {rows[k].e[5], rows[k].e[3:0]})
         if (!rows[k].e[5]) `CHK(decay_fast[b], rows[k].e[4])
         `CHK({idle, test_mode}, 2'b00)
      end
      // idle word, busy refusal, settle status, unmapped places
      axi_wr(dbsc_pkg::REG_WORD, 32'h00040000, r);
      `CHK(r, dbsc_pkg::RESP_OKAY)
      axi_rd(dbsc_pkg::REG_STAT, d, r);
      `CHK({r, d}, {dbsc_pkg::RESP_OKAY, 32'h00000001})
      axi_wr(dbsc_pkg::REG_WORD, 32'h000C8000, r);
      `CHK(r, dbsc_pkg::RESP_SLVERR)
      wait_for(0, 1'b1);
      repeat (8) @(posedge sys_clk);
      `CHK({idle, drv_on[1]}, 2'b10)
      axi_rd(dbsc_pkg::REG_WORD, d, r);
      `CHK(r, dbsc_pkg::RESP_SLVERR)
      axi_rd(4'h8, d, r);
      `CHK(r, dbsc_pkg::RESP_SLVERR)
      axi_wr(dbsc_pkg::REG_STAT, 32'h00000000, r);
      `CHK({r, link.ld_n}, {dbsc_pkg::RESP_SLVERR, 1'b1})
      send(20'hC8000);
      axi_rd(dbsc_pkg::REG_STAT, d, r);
      `CHK({r, d}, {dbsc_pkg::RESP_OKAY, 32'h00000002})
      // trip on bridge one: off time then blank, in oscillator rises
      chop_in[0] <= 1'b1;
      send(20'h20007);
      trip_in[0] <= 1'b1;
      wait_for(1, 1'b0);
      n0 = osc_cnt;
      wait_for(2, 1'b1);
      n1 = osc_cnt;
      wait_for(2, 1'b0);
      n2 = osc_cnt;
      `CHK((n1 - n0) inside {[14:16]}, 1'b1)
      `CHK((n2 - n1) inside {[23:25]}, 1'b1)
      // mixed decay: fast for its own count, or the whole off time when longer
      foreach (mix_w[j]) begin
         send(mix_w[j]);
         wait_for(2, 1'b1);
         wait_for(3, 1'b1);
         n0 = osc_cnt;
         wait_for(3, 1'b0);
         n1 = osc_cnt;
         `CHK((n1 - n0) inside {[6 + 8 * j:8 + 8 * j]}, 1'b1)
         `CHK({drv_on[0], sense_blank[0]}, {2{1'(j)}})
      end
      trip_in[0] <= 1'b0;
      // reset in mid-run clears the held words
      arst_n <= 1'b0;
      repeat (3) @(posedge sys_clk);
      `CHK({idle, dir_fwd, ref_div5, sr_mode, link.ld_n}, 10'h201)
      arst_n <= 1'b1;
      repeat (4) @(posedge sys_clk);
      send(20'hC8000);
      `CHK({idle, dir_fwd[1]}, 2'b01)
      complete_run();
   end
endmodule
`default_nettype wire
